// file: hw/but_pkg.sv
package but_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [5:0] OFS_CTRL_ONE  = 6'h00;
	localparam logic [5:0] OFS_CTRL_TWO  = 6'h04;
	localparam logic [5:0] OFS_REQ_EN    = 6'h0c;
	localparam logic [5:0] OFS_STATUS    = 6'h10;
	localparam logic [5:0] OFS_EVT_TRIG  = 6'h14;
	localparam logic [5:0] OFS_COUNTER   = 6'h24;
	localparam logic [5:0] OFS_DIVIDER   = 6'h28;
	localparam logic [5:0] OFS_RELOAD    = 6'h2c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_RUN          = 0;
	localparam int BIT_INHIBIT      = 1;
	localparam int BIT_SRC_SEL      = 2;
	localparam int BIT_SINGLE_SHOT  = 3;
	localparam int BIT_RELOAD_BUF   = 7;
	localparam int BIT_MIRROR_EN    = 11;
	localparam int BIT_MOS_LO       = 4;
	localparam int BIT_IRQ_EN       = 0;
	localparam int BIT_DMA_EN       = 8;
	localparam int BIT_FLAG         = 0;
	localparam int BIT_FORCE        = 0;
	localparam int BIT_MIRROR       = 31;
	// Writable masks of the control registers
	localparam logic [15:0] MASK_CTRL_ONE = 16'h088f;
	localparam logic [15:0] MASK_CTRL_TWO = 16'h0070;
	localparam logic [15:0] MASK_REQ_EN   = 16'h0101;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_CTRL   = 16'h0000;
	localparam logic [15:0] RST_DIV    = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'hffff;
	// ----------------------------------------
	// Trigger output codes
	// ----------------------------------------
	localparam logic [2:0] MOS_RESET  = 3'h0;
	localparam logic [2:0] MOS_ENABLE = 3'h1;
	localparam logic [2:0] MOS_UPDATE = 3'h2;
	// Access sizes
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage : but_pkg

// file: hw/but_timer.sv
`timescale 1ns/1ns
module but_timer
	import but_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        reg_sel_in,
	input  wire logic        reg_write_in,
	input  wire logic [5:0]  reg_addr_in,
	input  wire logic [1:0]  reg_size_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic        slave_reset_in,
	input  wire logic        gated_trigger_in,
	output logic             trigger_out,
	output logic             update_irq_out,
	output logic             update_dma_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] ctrl_one;
		logic [15:0] ctrl_two;
		logic [15:0] req_en;
		logic        update_flag;
		logic [15:0] counter_value;
		logic [15:0] divider_value;
		logic [15:0] divider_active;
		logic [15:0] div_count;
		logic [15:0] reload_limit;
		logic [15:0] reload_active;
		logic        effective_run_gate;
		logic        force_pend;
		logic        gate_s1;
		logic        gate_s2;
		logic        gate_s3;
		logic        gate_q;
		logic        slv_s1;
		logic        slv_s2;
		logic        slv_s3;
		logic        slv_q;
		logic        slv_prev;
		logic [31:0] rdata;
	} but_state_s;

	but_state_s st;
	but_state_s next_st;

	logic access_ok;
	logic wr;
	logic counter_tick;
	logic overflow;
	logic slave_upd;
	logic reinit;
	logic update_event;
	logic flag_set;
	logic stop_shot;
	logic [31:0] cnt_read;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	always_comb begin
		// Byte accesses are dropped: writes ignored, reads return zero
		access_ok = reg_sel_in && (reg_size_in == SIZE_HALF || reg_size_in == SIZE_WORD);
		wr        = access_ok && reg_write_in;
		// Prescaler divides by divider+1; ratio only changes at updates
		counter_tick = st.effective_run_gate && (st.div_count == st.divider_active);
		// Zero reload blocks counting entirely
		overflow  = counter_tick && (st.reload_active != 16'h0000)
			&& (st.counter_value == st.reload_active);
		slave_upd = st.slv_q && !st.slv_prev;
		reinit    = st.force_pend || slave_upd;
		update_event = (overflow || reinit) && !st.ctrl_one[BIT_INHIBIT];
		stop_shot = update_event && st.ctrl_one[BIT_SINGLE_SHOT];
		flag_set  = !st.ctrl_one[BIT_INHIBIT]
			&& (overflow || (reinit && !st.ctrl_one[BIT_SRC_SEL]));
		cnt_read  = {st.ctrl_one[BIT_MIRROR_EN] & st.update_flag, 15'h0000,
			st.counter_value};
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// Synchronisers: change counts when stages two and three agree
		next_st.gate_s1 = gated_trigger_in;
		next_st.gate_s2 = st.gate_s1;
		next_st.gate_s3 = st.gate_s2;
		if (st.gate_s2 == st.gate_s3) begin
			next_st.gate_q = st.gate_s3;
		end
		next_st.slv_s1 = slave_reset_in;
		next_st.slv_s2 = st.slv_s1;
		next_st.slv_s3 = st.slv_s2;
		if (st.slv_s2 == st.slv_s3) begin
			next_st.slv_q = st.slv_s3;
		end
		next_st.slv_prev = st.slv_q;
		next_st.force_pend = 1'b0;

		// Register writes
		if (wr) begin
			unique case (reg_addr_in)
				OFS_CTRL_ONE: next_st.ctrl_one = reg_wdata_in[15:0] & MASK_CTRL_ONE;
				OFS_CTRL_TWO: next_st.ctrl_two = reg_wdata_in[15:0] & MASK_CTRL_TWO;
				OFS_REQ_EN:   next_st.req_en   = reg_wdata_in[15:0] & MASK_REQ_EN;
				OFS_STATUS: begin
					if (!reg_wdata_in[BIT_FLAG]) begin
						next_st.update_flag = 1'b0;
					end
				end
				OFS_EVT_TRIG: next_st.force_pend = reg_wdata_in[BIT_FORCE];
				OFS_COUNTER:  next_st.counter_value = reg_wdata_in[15:0];
				OFS_DIVIDER:  next_st.divider_value = reg_wdata_in[15:0];
				OFS_RELOAD:   next_st.reload_limit  = reg_wdata_in[15:0];
				default: ;
			endcase
		end

		// Unbuffered reload follows the preload register directly
		if (!st.ctrl_one[BIT_RELOAD_BUF]) begin
			next_st.reload_active = st.reload_limit;
		end

		// Prescaler and counter
		if (reinit) begin
			next_st.div_count     = 16'h0000;
			next_st.counter_value = 16'h0000;
		end else if (st.effective_run_gate) begin
			next_st.div_count = counter_tick ? 16'h0000 : st.div_count + 16'h0001;
			if (overflow) begin
				next_st.counter_value = 16'h0000;
			end else if (counter_tick && st.reload_active != 16'h0000) begin
				next_st.counter_value = st.counter_value + 16'h0001;
			end
		end

		if (update_event) begin
			next_st.divider_active = st.divider_value;
			if (st.ctrl_one[BIT_RELOAD_BUF]) begin
				next_st.reload_active = st.reload_limit;
			end
			if (st.ctrl_one[BIT_SINGLE_SHOT]) begin
				next_st.ctrl_one[BIT_RUN] = 1'b0;
			end
		end
		// Hardware set wins over a same-cycle clear
		if (flag_set) begin
			next_st.update_flag = 1'b1;
		end

		// Run gate lags the run bit by one cycle
		// Single shot drops it with the run bit, so no tick follows the update
		next_st.effective_run_gate = st.ctrl_one[BIT_RUN] && !stop_shot;

		// Registered read data
		next_st.rdata = 32'h0000_0000;
		if (access_ok && !reg_write_in) begin
			unique case (reg_addr_in)
				OFS_CTRL_ONE: next_st.rdata = {16'h0000, st.ctrl_one};
				OFS_CTRL_TWO: next_st.rdata = {16'h0000, st.ctrl_two};
				OFS_REQ_EN:   next_st.rdata = {16'h0000, st.req_en};
				OFS_STATUS:   next_st.rdata = {31'h0000_0000, st.update_flag};
				OFS_COUNTER:  next_st.rdata = cnt_read;
				OFS_DIVIDER:  next_st.rdata = {16'h0000, st.divider_value};
				OFS_RELOAD:   next_st.rdata = {16'h0000, st.reload_limit};
				default:      next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st              <= '0;
			st.ctrl_one     <= RST_CTRL;
			st.ctrl_two     <= RST_CTRL;
			st.req_en       <= RST_CTRL;
			st.divider_value  <= RST_DIV;
			st.divider_active <= RST_DIV;
			st.reload_limit   <= RST_RELOAD;
			st.reload_active  <= RST_RELOAD;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Slave resets arrive through the synchroniser, so code 000 lags the actual reset
	always_comb begin
		unique case (st.ctrl_two[6:BIT_MOS_LO])
			MOS_RESET:  trigger_out = reinit;
			MOS_ENABLE: trigger_out = st.effective_run_gate | st.gate_q;
			MOS_UPDATE: trigger_out = update_event;
			default:    trigger_out = 1'b0;
		endcase
	end
	// Requests are one-cycle pulses per qualifying update
	assign update_irq_out = flag_set && st.req_en[BIT_IRQ_EN];
	assign update_dma_out = flag_set && st.req_en[BIT_DMA_EN];
	assign reg_rdata_out  = st.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_gate_on: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		($past(st.ctrl_one[BIT_RUN]) && st.ctrl_one[BIT_RUN]) |-> st.effective_run_gate)
		else $error("run gate not raised after run bit");
	a_gate_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!$past(st.ctrl_one[BIT_RUN]) |-> !st.effective_run_gate)
		else $error("run gate high without run bit");
	a_frozen_stopped: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(!st.effective_run_gate && !reinit && !wr) |=> $stable(st.counter_value))
		else $error("counter moved while stopped");
	a_zero_reload_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(st.reload_active == 16'h0000 && !reinit && !wr) |=> st.counter_value == $past(st.counter_value))
		else $error("counter moved with zero reload");
	a_wrap_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		overflow |=> st.counter_value == 16'h0000)
		else $error("overflow did not wrap");
	a_single_shot_stop: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(update_event && st.ctrl_one[BIT_SINGLE_SHOT]) |=> !st.ctrl_one[BIT_RUN])
		else $error("single shot did not stop");
	a_inhibit_no_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.ctrl_one[BIT_INHIBIT] |-> !update_irq_out && !update_dma_out && !update_event)
		else $error("update while inhibited");
	a_flag_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		flag_set |=> st.update_flag)
		else $error("flag not set");
	a_mirror_bit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(access_ok && !reg_write_in && reg_addr_in == OFS_COUNTER)
		|=> reg_rdata_out[BIT_MIRROR] == $past(st.ctrl_one[BIT_MIRROR_EN] && st.update_flag))
		else $error("mirror bit wrong");
	a_mirror_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(access_ok && !reg_write_in && reg_addr_in == OFS_COUNTER
		&& !st.ctrl_one[BIT_MIRROR_EN]) |=> !reg_rdata_out[BIT_MIRROR])
		else $error("mirror bit set while disabled");
	a_force_clears: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.force_pend |=> st.counter_value == 16'h0000 && st.div_count == 16'h0000 && !st.force_pend)
		else $error("force did not reinitialize");
	a_direct_reload: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!st.ctrl_one[BIT_RELOAD_BUF] |=> st.reload_active == $past(st.reload_limit))
		else $error("unbuffered reload lagging");

	a_div_shadow: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!update_event |=> $stable(st.divider_active))
		else $error("divider ratio changed without update");

	a_reload_shadow: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(st.ctrl_one[BIT_RELOAD_BUF] && !update_event) |=> $stable(st.reload_active))
		else $error("buffered reload changed without update");

	a_write_one: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(wr && reg_addr_in == OFS_STATUS && reg_wdata_in[BIT_FLAG] && st.update_flag)
		|=> st.update_flag)
		else $error("writing one cleared the flag");

	a_request_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(update_irq_out || update_dma_out) |=> st.update_flag)
		else $error("request without flag");

	a_byte_refused: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(reg_sel_in && reg_size_in != SIZE_HALF && reg_size_in != SIZE_WORD)
		|=> reg_rdata_out == 32'h0000_0000)
		else $error("byte access answered");

	a_force_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(st.force_pend && !st.ctrl_one[BIT_INHIBIT] && !st.ctrl_one[BIT_SRC_SEL])
		|=> st.update_flag)
		else $error("forced update did not set flag");

	a_inhibit_reinit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(st.force_pend && st.ctrl_one[BIT_INHIBIT])
		|=> (st.counter_value == 16'h0000 && $stable(st.divider_active)))
		else $error("inhibited force misbehaved");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	c_overflow: cover property (@(posedge ref_clk_in) overflow && update_irq_out);
	c_forced: cover property (@(posedge ref_clk_in) st.force_pend && update_event);
	c_single: cover property (@(posedge ref_clk_in) update_event && st.ctrl_one[BIT_SINGLE_SHOT]);
	c_slave: cover property (@(posedge ref_clk_in) slave_upd && update_event);
	c_inhibit: cover property (@(posedge ref_clk_in) overflow && st.ctrl_one[BIT_INHIBIT]);
endmodule : but_timer

// file: dv/tb.sv
`timescale 1ns/1ns
module tb;
	import but_pkg::*;
	logic        ref_clk_in;
	logic        rstn_in;
	logic        reg_sel_in;
	logic        reg_write_in;
	logic [5:0]  reg_addr_in;
	logic [1:0]  reg_size_in;
	logic [31:0] reg_wdata_in;
	logic [31:0] reg_rdata_out;
	logic        slave_reset_in;
	logic        gated_trigger_in;
	logic        trigger_out;
	logic        update_irq_out;
	logic        update_dma_out;
	logic [31:0] rd;
	int          mismatches, n_tests, cnt_irq, cnt_dma, cnt_trg, dv, rl;
	int          mdl[int];
	int          per_q[$];
	logic [5:0]  offs[9] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_REQ_EN, OFS_STATUS, OFS_EVT_TRIG,
	                         OFS_COUNTER, OFS_DIVIDER, OFS_RELOAD, 6'h08};
	logic [31:0] rstv[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffff, 32'h0};

	but_timer but_timer_i (
		.ref_clk_in       (ref_clk_in),
		.rstn_in          (rstn_in),
		.reg_sel_in       (reg_sel_in),
		.reg_write_in     (reg_write_in),
		.reg_addr_in      (reg_addr_in),
		.reg_size_in      (reg_size_in),
		.reg_wdata_in     (reg_wdata_in),
		.reg_rdata_out    (reg_rdata_out),
		.slave_reset_in   (slave_reset_in),
		.gated_trigger_in (gated_trigger_in),
		.trigger_out      (trigger_out),
		.update_irq_out   (update_irq_out),
		.update_dma_out   (update_dma_out)
	);

	// ----------------------------------------
	// Clock, pulse counters, watchdog
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(negedge ref_clk_in) begin
		if (update_irq_out === 1'b1) cnt_irq++;
		if (update_dma_out === 1'b1) cnt_dma++;
		if (trigger_out === 1'b1) cnt_trg++;
	end
	initial begin
		#400000;
		mismatches++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// One strobe cycle; read data is settled by the following falling edge
	task automatic acc(input logic w, input logic [5:0] a, input logic [1:0] sz, input logic [31:0] d);
		@(negedge ref_clk_in);
		reg_sel_in = 1'b1;
		reg_write_in = w;
		reg_addr_in = a;
		reg_size_in = sz;
		reg_wdata_in = d;
		@(negedge ref_clk_in);
		reg_sel_in = 1'b0;
		rd = reg_rdata_out;
	endtask : acc
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, SIZE_WORD, d);
		if (a == OFS_DIVIDER || a == OFS_RELOAD) mdl[a] = int'(d[15:0]);
	endtask : wr
	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		acc(1'b0, a, SIZE_WORD, 32'h0);
		check(rd, exp);
	endtask : rdchk
	task automatic period(input int exp);
		int k;
		k = 0;
		while (update_irq_out !== 1'b1 && k < 5000) begin
			@(negedge ref_clk_in);
			k++;
		end
		@(negedge ref_clk_in);
		k = 1;
		while (update_irq_out !== 1'b1 && k < 5000) begin
			@(negedge ref_clk_in);
			k++;
		end
		check(32'(k), 32'(exp));
	endtask : period
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{rstn_in, reg_sel_in, reg_write_in, slave_reset_in, gated_trigger_in} = 5'h0;
		{reg_addr_in, reg_size_in, reg_wdata_in} = '0;
		rd = $urandom(32'h575ca1a2);
		repeat (8) @(negedge ref_clk_in);
		rstn_in = 1'b1;
		foreach (offs[i]) rdchk(offs[i], rstv[i]);
		acc(1'b0, OFS_RELOAD, 2'h0, 32'h0);
		check(rd, 32'h0);
		acc(1'b0, OFS_RELOAD, SIZE_HALF, 32'h0);
		check(rd, 32'hffff);
		wr(OFS_CTRL_TWO, 32'h0070);
		rdchk(OFS_CTRL_TWO, 32'h0070);
		check(32'(trigger_out), 32'h0);
		wr(OFS_REQ_EN, 32'h0101);
		rdchk(OFS_REQ_EN, 32'h0101);
		wr(OFS_CTRL_TWO, 32'h0);
		$display("test reset_and_map done");
		cnt_irq = 0;
		cnt_dma = 0;
		for (int i = 0; i < 3; i++) begin
			dv = $urandom_range(3);
			rl = $urandom_range(6, 1);
			wr(OFS_CTRL_ONE, 32'h0);
			wr(OFS_RELOAD, 32'(rl));
			wr(OFS_DIVIDER, 32'(dv));
			rdchk(OFS_RELOAD, 32'(mdl[OFS_RELOAD]));
			rdchk(OFS_DIVIDER, 32'(mdl[OFS_DIVIDER]));
			per_q.push_back((dv + 1) * (rl + 1));
			wr(OFS_EVT_TRIG, 32'h1);
			wr(OFS_CTRL_ONE, 32'h1);
			period(per_q.pop_front());
		end
		wr(OFS_CTRL_ONE, 32'h0);
		check(32'(cnt_dma), 32'(cnt_irq));
		$display("test count_period done");
		for (int b = 0; b < 2; b++) begin
			wr(OFS_CTRL_ONE, 32'(b) << 7);
			wr(OFS_RELOAD, 32'h3);
			wr(OFS_DIVIDER, 32'h1);
			wr(OFS_EVT_TRIG, 32'h1);
			wr(OFS_RELOAD, 32'h7);
			cnt_irq = 0;
			wr(OFS_CTRL_ONE, (32'(b) << 7) | 32'h1);
			repeat (12) @(negedge ref_clk_in);
			check(32'(cnt_irq), 32'(b));
		end
		$display("test reload_buffer done");
		wr(OFS_REQ_EN, 32'h0001);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL_ONE, 32'(i) << 1);
			wr(OFS_STATUS, 32'h0);
			wr(OFS_COUNTER, 32'h5);
			cnt_irq = 0;
			cnt_dma = 0;
			wr(OFS_EVT_TRIG, 32'h1);
			repeat (2) @(negedge ref_clk_in);
			check(32'(cnt_irq), 32'(i == 0));
			check(32'(cnt_dma), 32'h0);
			rdchk(OFS_STATUS, 32'(i == 0));
			rdchk(OFS_COUNTER, 32'h0);
		end
		wr(OFS_CTRL_ONE, 32'h800);
		wr(OFS_EVT_TRIG, 32'h1);
		rdchk(OFS_COUNTER, 32'h8000_0000);
		wr(OFS_STATUS, 32'h1);
		rdchk(OFS_STATUS, 32'h1);
		wr(OFS_CTRL_ONE, 32'h0);
		rdchk(OFS_COUNTER, 32'h0);
		wr(OFS_STATUS, 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		$display("test force_and_flag done");
		wr(OFS_RELOAD, 32'h3);
		wr(OFS_DIVIDER, 32'h0);
		cnt_irq = 0;
		wr(OFS_CTRL_ONE, 32'h3);
		repeat (30) @(negedge ref_clk_in);
		check(32'(cnt_irq), 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		acc(1'b0, OFS_COUNTER, SIZE_WORD, 32'h0);
		check(32'(rd[15:0] < 16'h4), 32'h1);
		wr(OFS_CTRL_ONE, 32'h0);
		wr(OFS_EVT_TRIG, 32'h1);
		@(negedge ref_clk_in);
		cnt_irq = 0;
		wr(OFS_CTRL_ONE, 32'h9);
		repeat (20) @(negedge ref_clk_in);
		check(32'(cnt_irq), 32'h1);
		rdchk(OFS_CTRL_ONE, 32'h8);
		rdchk(OFS_COUNTER, 32'h0);
		$display("test inhibit_single_shot done");
		wr(OFS_CTRL_TWO, 32'h10);
		repeat (2) @(negedge ref_clk_in);
		check(32'(trigger_out), 32'h0);
		gated_trigger_in = 1'b1;
		repeat (6) @(negedge ref_clk_in);
		check(32'(trigger_out), 32'h1);
		gated_trigger_in = 1'b0;
		wr(OFS_CTRL_ONE, 32'h1);
		repeat (2) @(negedge ref_clk_in);
		check(32'(trigger_out), 32'h1);
		wr(OFS_CTRL_ONE, 32'h0);
		wr(OFS_CTRL_TWO, 32'h0);
		cnt_trg = 0;
		wr(OFS_EVT_TRIG, 32'h1);
		repeat (3) @(negedge ref_clk_in);
		check(32'(cnt_trg), 32'h1);
		wr(OFS_COUNTER, 32'h2);
		wr(OFS_STATUS, 32'h0);
		cnt_trg = 0;
		cnt_irq = 0;
		slave_reset_in = 1'b1;
		repeat (8) @(negedge ref_clk_in);
		slave_reset_in = 1'b0;
		check(32'(cnt_trg), 32'h1);
		check(32'(cnt_irq), 32'h1);
		rdchk(OFS_COUNTER, 32'h0);
		wr(OFS_CTRL_TWO, 32'h20);
		cnt_trg = 0;
		cnt_irq = 0;
		wr(OFS_CTRL_ONE, 32'h1);
		repeat (40) @(negedge ref_clk_in);
		wr(OFS_CTRL_ONE, 32'h0);
		check(32'(cnt_trg), 32'(cnt_irq));
		check(32'(cnt_irq > 5), 32'h1);
		$display("test trigger_out done");
		wr(OFS_RELOAD, 32'h0);
		wr(OFS_EVT_TRIG, 32'h1);
		@(negedge ref_clk_in);
		cnt_irq = 0;
		wr(OFS_CTRL_ONE, 32'h1);
		repeat (20) @(negedge ref_clk_in);
		rdchk(OFS_COUNTER, 32'h0);
		check(32'(cnt_irq), 32'h0);
		$display("test zero_reload done");
		tally_and_finish();
	end
endmodule : tb
